// ### src/adc_mux_pkg.sv
// Purpose: shared constants and types of the converter selection and result block
// Assumes: APB slave with 8-bit byte addresses, 32-bit data
// Notes: on behaviour below
//
// Notes on behaviour
// R1 - result bytes hold result after completion
// R2 - single-ended result is unsigned 10-bit code
// R3 - differential result is 10-bit two's complement
// R4 - result bit 9 is differential sign
// R5 - selection register at 0x7C, resets zero
// R6 - reference field decodes four reference sources
// R7 - reference change mid-conversion waits for completion
// R8 - left-align bit chooses result alignment
// R9 - alignment change shows in bytes immediately
// R10 - software uses 2.56V internal for differential
// R11 - same input on both differential terminals allowed
// R12 - shared pins stay quiet during conversion
// R13 - completion flag sets, cleared by one or vector
// R14 - channel change mid-conversion waits for completion
// R15 - byte layout for left and right alignment
package adc_mux_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ADDR_SEL      = 8'h7C;
   localparam logic [7:0] ADDR_RES_LO   = 8'h70;
   localparam logic [7:0] ADDR_RES_HI   = 8'h74;
   localparam logic [7:0] ADDR_CTRL     = 8'h78;
   localparam logic [7:0] ADDR_IRQ_ST   = 8'h68;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h6C;

   localparam int CTRL_FLAG_BIT  = 0;
   localparam int CTRL_BUSY_BIT  = 1;
   localparam int CTRL_START_BIT = 2;

   localparam logic [7:0] SEL_RESET    = 8'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   localparam logic [9:0] DIFF_ZERO    = 10'h200;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int ADC_DIV       = 8;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic [1:0] referenceSelect;
      logic       leftAlignResult;
      logic [4:0] channelGainSelect;
   } sel_cfg_t;

   typedef enum logic [1:0] {
      REF_EXT      = 2'b00,
      REF_SUPPLY   = 2'b01,
      REF_INT_1V1  = 2'b10,
      REF_INT_2V56 = 2'b11
   } ref_sel_t;

   typedef enum logic [1:0] {
      GAIN_NONE = 2'b00,
      GAIN_1X   = 2'b01,
      GAIN_10X  = 2'b10,
      GAIN_200X = 2'b11
   } gain_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_BUSY  = 2'b10
   } conv_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

endpackage

// ### src/adc_clk_div.sv
// Purpose: one-cycle enable marking each converter clock edge
// Assumes: fixed division factor from the package
// Notes: the prescaler select is outside this block
`timescale 1ns/10ps
module adc_clk_div
   import adc_mux_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   // enable out
   output logic      adcTick
);
   logic [7:0] divCount_reg;
   logic       wrap;

   assign wrap = (divCount_reg == 8'(ADC_DIV - 1));

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         divCount_reg <= 8'h00;
         adcTick      <= 1'b0;
      end else begin
         divCount_reg <= wrap ? 8'h00 : divCount_reg + 8'h01;
         adcTick      <= wrap;
      end
   end
endmodule

// ### src/adc_result_format.sv
// Purpose: place the stored 10-bit result into the two result bytes
// Assumes: alignment bit taken live from the selection register
// Notes: purely combinational so an alignment change shows at once
`timescale 1ns/10ps
module adc_result_format (
   // stored result and alignment
   input  wire logic [9:0] result,
   input  wire logic       leftAlign,
   // byte view
   output logic      [7:0] resultHighByte,
   output logic      [7:0] resultLowByte
);
   // R15 byte layout
   assign resultHighByte = leftAlign ? result[9:2] : {6'h00, result[9:8]};
   assign resultLowByte  = leftAlign ? {result[1:0], 6'h00} : result[7:0];
endmodule

// ### src/adc_mux_result.sv
// Purpose: selection register, conversion hand-off and result bytes of the converter
// Assumes: the successive-approximation core runs on clk_sys and returns one code per
//          conversion with a one-cycle done pulse; differential codes come offset-binary
// Notes: registers on APB; one level interrupt for conversion complete
`timescale 1ns/10ps
module adc_mux_result
   import adc_mux_pkg::*;
(
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   sys_rst,
   // register bus
   input  wire adc_mux_pkg::apb_req_t  apbReq,
   output adc_mux_pkg::apb_rsp_t       apbRsp,
   // converter core
   input  wire logic                   sarDone,
   input  wire logic [9:0]             sarCode,
   output logic                        convStart,
   output logic                        convBusy,
   // analog selection in use
   output adc_mux_pkg::ref_sel_t       refActive,
   output logic                        intRefEnable,
   output logic [4:0]                  chanActive,
   output logic                        diffActive,
   output adc_mux_pkg::gain_t          gainActive,
   // interrupt
   input  wire logic                   vectorAck,
   output logic                        irq
);
   import adc_mux_pkg::*;

   // ****************************************
   // channel decoding
   // ****************************************
   // R11 pairs with equal inputs are valid differential codes
   function automatic logic chan_is_diff(input logic [4:0] ch);
      return (ch >= 5'h08) && (ch <= 5'h1D);
   endfunction

   function automatic gain_t chan_gain(input logic [4:0] ch);
      if (!chan_is_diff(ch))
         return GAIN_NONE;
      else if (ch[4:3] == 2'b01)
         return ch[1] ? GAIN_200X : GAIN_10X;
      else
         return GAIN_1X;
   endfunction

   // ****************************************
   // state
   // ****************************************
   sel_cfg_t    selReg;
   conv_state_t state_reg;
   conv_state_t state_next;
   logic [9:0]  resultReg;
   logic        flagReg;
   logic        irqStatusReg;
   logic        irqMaskReg;
   logic        irqSnapReg;
   logic        irqStatus_next;
   logic        adcTick;
   logic [7:0]  hiByte;
   logic [7:0]  loByte;
   logic [31:0] readData;
   logic        addrHit;

   wire setupPhase = apbReq.psel & ~apbReq.penable;
   wire accessDone = apbReq.psel & apbReq.penable & apbRsp.pready;
   wire wrDone     = accessDone & apbReq.pwrite & addrHit;
   wire rdDone     = accessDone & ~apbReq.pwrite;
   wire wrSel      = wrDone & (apbReq.paddr == ADDR_SEL);
   wire wrCtrl     = wrDone & (apbReq.paddr == ADDR_CTRL);
   wire wrMask     = wrDone & (apbReq.paddr == ADDR_IRQ_MASK);
   wire rdIrqSt    = rdDone & (apbReq.paddr == ADDR_IRQ_ST);
   wire startReq   = wrCtrl & apbReq.pwdata[CTRL_START_BIT];
   wire flagW1c    = wrCtrl & apbReq.pwdata[CTRL_FLAG_BIT];
   wire convEnd    = (state_reg == ST_BUSY) & sarDone;
   // R7 selection follows register unless a conversion holds it
   wire selTrack   = (state_reg != ST_BUSY) | sarDone;

   adc_clk_div i_adc_clk_div (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .adcTick (adcTick)
   );

   // R8 R9 live alignment from the register
   adc_result_format i_adc_result_format (
      .result         (resultReg),
      .leftAlign      (selReg.leftAlignResult),
      .resultHighByte (hiByte),
      .resultLowByte  (loByte)
   );

   // ****************************************
   // address decode
   // ****************************************
   always_comb begin
      addrHit  = 1'b1;
      readData = 32'h0000_0000;
      if (apbReq.paddr == ADDR_SEL)
         readData = {24'h00_0000, selReg};
      else if (apbReq.paddr == ADDR_RES_LO)
         readData = {24'h00_0000, loByte};
      else if (apbReq.paddr == ADDR_RES_HI)
         readData = {24'h00_0000, hiByte};
      else if (apbReq.paddr == ADDR_CTRL)
         readData = {30'h0000_0000, state_reg != ST_IDLE, flagReg};
      else if (apbReq.paddr == ADDR_IRQ_ST)
         readData = {31'h0000_0000, irqStatusReg};
      else if (apbReq.paddr == ADDR_IRQ_MASK)
         readData = {31'h0000_0000, irqMaskReg};
      else
         addrHit = 1'b0;
   end

   // ****************************************
   // bus answer
   // ****************************************
   // one wait-free access phase: ready is set for the cycle after setup
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         apbRsp     <= '0;
         irqSnapReg <= 1'b0;
      end else begin
         apbRsp.pready  <= setupPhase;
         apbRsp.pslverr <= setupPhase & ~addrHit;
         if (setupPhase) begin
            apbRsp.prdata <= readData;
            irqSnapReg    <= irqStatusReg;
         end
      end
   end

   // ****************************************
   // selection register
   // ****************************************
   // R5 read/write selection register
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         selReg <= SEL_RESET;
      else if (wrSel)
         selReg <= apbReq.pwdata[7:0];
   end

   // R7 R14 locked copy used by the analog side
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         refActive    <= REF_EXT;
         intRefEnable <= 1'b0;
         chanActive   <= 5'h00;
         diffActive   <= 1'b0;
         gainActive   <= GAIN_NONE;
      end else if (selTrack) begin
         refActive    <= ref_sel_t'(selReg.referenceSelect);
         // R6 internal reference only off for the external pin
         intRefEnable <= (selReg.referenceSelect != REF_EXT);
         chanActive   <= selReg.channelGainSelect;
         diffActive   <= chan_is_diff(selReg.channelGainSelect);
         gainActive   <= chan_gain(selReg.channelGainSelect);
      end
   end

   // ****************************************
   // conversion sequence
   // ****************************************
   // conversion begins on the next converter clock edge after the request
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (startReq)
               state_next = ST_ARMED;
         end
         ST_ARMED: begin
            if (adcTick)
               state_next = ST_BUSY;
         end
         ST_BUSY: begin
            if (sarDone)
               state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         convStart <= 1'b0;
         convBusy  <= 1'b0;
      end else begin
         state_reg <= state_next;
         convStart <= (state_reg == ST_ARMED) & adcTick;
         convBusy  <= (state_next == ST_BUSY);
      end
   end

   // ****************************************
   // result capture
   // ****************************************
   // R1 R2 R3 R4 store on completion only; diff code flips offset bit to sign
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         resultReg <= RESULT_RESET;
      else if (convEnd)
         resultReg <= diffActive ? (sarCode ^ DIFF_ZERO) : sarCode;
   end

   // ****************************************
   // flag and interrupt
   // ****************************************
   // R13 completion sets, write-one or vector clears the flag, status read clears the status, set wins
   assign irqStatus_next = convEnd | (irqStatusReg & ~(rdIrqSt & irqSnapReg));

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         flagReg      <= 1'b0;
         irqStatusReg <= 1'b0;
         irqMaskReg   <= 1'b0;
         irq          <= 1'b0;
      end else begin
         flagReg      <= convEnd | (flagReg & ~(flagW1c | vectorAck));
         irqStatusReg <= irqStatus_next;
         if (wrMask)
            irqMaskReg <= apbReq.pwdata[0];
         irq <= irqStatus_next & (wrMask ? apbReq.pwdata[0] : irqMaskReg);
      end
   end

   // ****************************************
   // checks
   // ****************************************
   chk_flag_on_done: assert property (@(posedge clk_sys) disable iff (sys_rst) // R13
      convEnd |=> flagReg)
      else $error("completion flag not set after done");

   chk_ref_locked: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
      (state_reg == ST_BUSY) && !sarDone |=> $stable(refActive))
      else $error("reference moved during conversion");

   chk_ref_follow: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
      (state_reg == ST_IDLE) |=> refActive == $past(selReg.referenceSelect))
      else $error("reference not tracking while idle");

   chk_chan_locked: assert property (@(posedge clk_sys) disable iff (sys_rst) // R14
      (state_reg == ST_BUSY) && !sarDone ##1 (state_reg == ST_BUSY) |-> $stable(chanActive))
      else $error("channel moved during conversion");

   chk_int_ref: assert property (@(posedge clk_sys) disable iff (sys_rst) // R6
      intRefEnable == (refActive != REF_EXT))
      else $error("internal reference enable wrong");

   chk_single_code: assert property (@(posedge clk_sys) disable iff (sys_rst) // R2
      convEnd && !diffActive |=> resultReg == $past(sarCode))
      else $error("single-ended code altered");

   chk_diff_sign: assert property (@(posedge clk_sys) disable iff (sys_rst) // R4
      convEnd && diffActive |=> resultReg[9] == !$past(sarCode[9]) && resultReg[8:0] == $past(sarCode[8:0]))
      else $error("differential sign wrong");

   chk_result_held: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
      !convEnd |=> $stable(resultReg))
      else $error("result changed without completion");

   chk_sel_write: assert property (@(posedge clk_sys) disable iff (sys_rst) // R5
      wrSel |=> selReg == $past(apbReq.pwdata[7:0]))
      else $error("selection write lost");

   chk_left_layout: assert property (@(posedge clk_sys) disable iff (sys_rst) // R9
      selReg.leftAlignResult |-> hiByte == resultReg[9:2] && loByte == {resultReg[1:0], 6'h00})
      else $error("left layout wrong");

   chk_right_layout: assert property (@(posedge clk_sys) disable iff (sys_rst) // R15
      !selReg.leftAlignResult |-> hiByte == {6'h00, resultReg[9:8]} && loByte == resultReg[7:0])
      else $error("right layout wrong");

   chk_start_edge: assert property (@(posedge clk_sys) disable iff (sys_rst)
      convStart |-> $past(adcTick) && $past(state_reg == ST_ARMED))
      else $error("start not on converter clock edge");

   chk_bus_ready: assert property (@(posedge clk_sys) disable iff (sys_rst)
      setupPhase |=> apbRsp.pready)
      else $error("no ready after setup");

   chk_bus_error: assert property (@(posedge clk_sys) disable iff (sys_rst)
      setupPhase && !addrHit |=> apbRsp.pslverr && apbRsp.prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   chk_irq_level: assert property (@(posedge clk_sys) disable iff (sys_rst) // R13
      irq == (irqStatusReg & irqMaskReg))
      else $error("interrupt level wrong");

   chk_flag_clear: assert property (@(posedge clk_sys) disable iff (sys_rst) // R13
      flagReg && !convEnd && (flagW1c || vectorAck) |=> !flagReg)
      else $error("completion flag not cleared");

   chk_busy_end: assert property (@(posedge clk_sys) disable iff (sys_rst) // R13
      convEnd |=> !convBusy)
      else $error("busy still set after completion");

   chk_gain_decode: assert property (@(posedge clk_sys) disable iff (sys_rst) // R14
      diffActive == (gainActive != GAIN_NONE))
      else $error("gain without differential channel");

endmodule

// ### testbench/sar_core_model.sv
// Purpose: behavioural converter core that answers each conversion start
// Assumes: same clock as the block; one code per conversion
// Notes: the code bus is only valid with the done pulse
`timescale 1ns/10ps
module sar_core_model #(
   parameter int LATENCY = 20
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // block side
   input  wire logic       convStart,
   output logic            sarDone,
   output logic [9:0]      sarCode,
   // code to return, set by the bench
   input  wire logic [9:0] codeNext
);
   int         count;
   logic [9:0] lastCode;

   // ****************************************
   // conversion timing
   // ****************************************
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         count    <= 0;
         sarDone  <= 1'b0;
         lastCode <= 10'h000;
      end else begin
         sarDone <= 1'b0;
         if (convStart) begin
            count <= LATENCY;
         end else if (count == 1) begin
            sarDone  <= 1'b1;
            lastCode <= codeNext;
            count    <= 0;
         end else if (count > 1) begin
            count <= count - 1;
         end
      end
   end

   // outside the pulse the bus shows garbage, so a late sample cannot pass
   assign sarCode = sarDone ? lastCode : ~lastCode;
endmodule

// ### testbench/test_adc_mux_result.sv
// Purpose: register-level tests of selection, deferral and result layout
// Assumes: one-cycle APB answer, core model returns codes offset-binary
// Notes: alignment checks reuse the stored result of earlier conversions
`timescale 1ns/10ps
module test_adc_mux_result;
   import adc_mux_pkg::*;
   logic        clk_sys, sys_rst, vectorAck, sarDone, convStart, convBusy;
   logic        intRefEnable, diffActive, irq, err;
   apb_req_t    apbReq;
   apb_rsp_t    apbRsp;
   logic [9:0]  sarCode, codeNext;
   ref_sel_t    refActive;
   logic [4:0]  chanActive;
   gain_t       gainActive;
   logic [31:0] rd;
   int          errCount, nCompared;

   adc_mux_result i_adc_mux_result (.clk_sys(clk_sys), .sys_rst(sys_rst), .apbReq(apbReq),
      .apbRsp(apbRsp), .sarDone(sarDone), .sarCode(sarCode), .convStart(convStart),
      .convBusy(convBusy), .refActive(refActive), .intRefEnable(intRefEnable),
      .chanActive(chanActive), .diffActive(diffActive), .gainActive(gainActive),
      .vectorAck(vectorAck), .irq(irq));
   sar_core_model i_sar_core_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .convStart(convStart),
      .sarDone(sarDone), .sarCode(sarCode), .codeNext(codeNext));

   // ****************************************
   // bus and check tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      int n;
      n = 0;
      @(posedge clk_sys);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
      @(posedge clk_sys);
      apbReq.penable <= 1'b1;
      // request stands until ready is seen high at a rising edge
      do begin
         @(posedge clk_sys);
         n++;
      end while (apbRsp.pready !== 1'b1 && n < 20);
      chk("pready", 32'(apbRsp.pready), 32'h1);
      rd  = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel    <= 1'b0;
      apbReq.penable <= 1'b0;
      // let outputs launched at this edge settle before callers look
      @(negedge clk_sys);
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      apb(1'b1, addr, data);
   endtask

   task automatic rdChk(input string what, input logic [7:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      chk(what, rd, exp);
   endtask

   task automatic busyWait(input logic level);
      int n;
      n = 0;
      while (convBusy !== level && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      chk("busy", 32'(convBusy), 32'(level));
   endtask

   task automatic convert(input logic [9:0] code);
      // input to the core kept still until the conversion ends
      codeNext <= code;
      wr(ADDR_CTRL, 32'h4);
      busyWait(1'b1);
   endtask

   task automatic endSim;
      $display("compared %0d mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ****************************************
   // clock, reset and tests
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
   end

   initial begin
      #2000000;
      errCount++;
      endSim();
   end

   initial begin
      sys_rst = 1'b1;
      apbReq = '0;
      vectorAck = 1'b0;
      codeNext = 10'h000;
      errCount = 0;
      nCompared = 0;
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rdChk("sel reset", ADDR_SEL, 32'h0);
      rdChk("ctrl reset", ADDR_CTRL, 32'h0);
      rdChk("result hi reset", ADDR_RES_HI, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'(err), 32'h1);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_SEL, 32'(i * 64 + 3));
         rdChk("sel readback", ADDR_SEL, 32'(i * 64 + 3));
         chk("ref active", 32'(refActive), 32'(i));
         chk("int ref enable", 32'(intRefEnable), 32'(i != 0));
      end
      $display("test reference decode done");
      wr(ADDR_IRQ_MASK, 32'h1);
      wr(ADDR_SEL, 32'h43);
      convert(10'h3FF);
      wr(ADDR_SEL, 32'hC9);
      chk("ref held", 32'(refActive), 32'h1);
      chk("chan held", 32'(chanActive), 32'h3);
      busyWait(1'b0);
      chk("irq", 32'(irq), 32'h1);
      chk("ref after", 32'(refActive), 32'h3);
      chk("chan after", 32'(chanActive), 32'h9);
      chk("diff", 32'(diffActive), 32'h1);
      rdChk("se hi right", ADDR_RES_HI, 32'h03);
      rdChk("se lo right", ADDR_RES_LO, 32'hFF);
      wr(ADDR_SEL, 32'hE9);
      rdChk("se hi left", ADDR_RES_HI, 32'hFF);
      rdChk("se lo left", ADDR_RES_LO, 32'hC0);
      rdChk("flag set", ADDR_CTRL, 32'h1);
      rdChk("irq status", ADDR_IRQ_ST, 32'h1);
      chk("irq cleared", 32'(irq), 32'h0);
      wr(ADDR_CTRL, 32'h1);
      rdChk("flag cleared", ADDR_CTRL, 32'h0);
      $display("test single ended done");
      // differential with the 2.56V internal reference only
      wr(ADDR_SEL, 32'hED);
      convert(10'h070);
      wr(ADDR_SEL, 32'hCD);
      rdChk("live align", ADDR_RES_HI, 32'h03);
      wr(ADDR_SEL, 32'hED);
      busyWait(1'b0);
      @(posedge clk_sys);
      vectorAck <= 1'b1;
      @(posedge clk_sys);
      vectorAck <= 1'b0;
      rdChk("vector clear", ADDR_CTRL, 32'h0);
      rdChk("diff lo left", ADDR_RES_LO, 32'h00);
      rdChk("diff hi left", ADDR_RES_HI, 32'h9C);
      chk("gain", 32'(gainActive), 32'(GAIN_10X));
      wr(ADDR_SEL, 32'hCD);
      rdChk("diff lo right", ADDR_RES_LO, 32'h70);
      rdChk("sign right", ADDR_RES_HI, 32'h02);
      $display("test differential done");
      wr(ADDR_IRQ_MASK, 32'h0);
      wr(ADDR_SEL, 32'hCA);
      @(negedge clk_sys);
      chk("gain 200x", 32'(gainActive), 32'(GAIN_200X));
      wr(ADDR_SEL, 32'hD0);
      @(negedge clk_sys);
      chk("gain 1x", 32'(gainActive), 32'(GAIN_1X));
      wr(ADDR_SEL, 32'hDE);
      @(negedge clk_sys);
      chk("fixed input single", 32'(diffActive), 32'h0);
      wr(ADDR_SEL, 32'hC8);
      convert(10'h200);
      wr(ADDR_CTRL, 32'h4);
      busyWait(1'b0);
      chk("masked irq", 32'(irq), 32'h0);
      rdChk("offset hi", ADDR_RES_HI, 32'h00);
      rdChk("offset lo", ADDR_RES_LO, 32'h00);
      repeat (20) @(negedge clk_sys);
      chk("start ignored", 32'(convBusy), 32'h0);
      convert(10'h3FF);
      busyWait(1'b0);
      rdChk("max positive hi", ADDR_RES_HI, 32'h01);
      rdChk("max positive lo", ADDR_RES_LO, 32'hFF);
      $display("test offset and range done");
      endSim();
   end
endmodule
